// ---- src/bsio_pkg.sv ----
package bsio_pkg;

  // ----------------------------------------------------------------
  // I/O addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] BSIO_ADDR_CTRL     = 16'h01d0;
  localparam logic [15:0] BSIO_ADDR_IDENT    = 16'h01d1;
  localparam logic [15:0] BSIO_ADDR_JUMPER   = 16'h01d2;
  localparam logic [15:0] BSIO_ADDR_XCVR     = 16'h01da;
  localparam logic [15:0] BSIO_ADDR_PORT4_LO = 16'h02e8;
  localparam logic [15:0] BSIO_ADDR_PORT4_HI = 16'h02ef;
  localparam logic [15:0] BSIO_ADDR_PORT3_LO = 16'h03e8;
  localparam logic [15:0] BSIO_ADDR_PORT3_HI = 16'h03ef;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BSIO_CTRL_LAMP_BIT    = 7;
  localparam int BSIO_CTRL_HEAT_BIT    = 5;
  localparam int BSIO_ID_GRADE_BIT     = 2;
  localparam int BSIO_JMP_VIDEO_BIT    = 6;
  localparam int BSIO_JMP_SYSTEM_BIT   = 5;
  localparam int BSIO_XC_P4_TX485_BIT  = 6;
  localparam int BSIO_XC_P4_RX_BIT     = 5;
  localparam int BSIO_XC_P4_TX422_BIT  = 4;
  localparam int BSIO_XC_P3_TX485_BIT  = 2;
  localparam int BSIO_XC_P3_RX_BIT     = 1;
  localparam int BSIO_XC_P3_TX422_BIT  = 0;

  // Writable bits of the transceiver register; others are reserved
  localparam logic [7:0] BSIO_XC_WMASK   = 8'h77;
  // Reserved bits read as this constant
  localparam logic [7:0] BSIO_RSVD_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       BSIO_LAMP_RESET = 1'b1;  // Lamp dark
  localparam logic [7:0] BSIO_XC_RESET   = 8'h00; // All drivers off

  // Compare pipeline depth of the heat monitor
  localparam int BSIO_HEAT_LATENCY = 1;

endpackage : bsio_pkg

// ---- src/bsio_heat_cmp.sv ----
`timescale 1ns/1ps

// Compares die temperature against the configured threshold every cycle
module bsio_heat_cmp
  import bsio_pkg::*;
#(
  parameter int TEMP_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Temperature and threshold
  input  wire logic [TEMP_W-1:0] die_temp,
  input  wire logic [TEMP_W-1:0] threshold,
  // Result
  output logic                   over_ff
);

  // ----------------------------------------------------------------
  // Registered compare, strictly above threshold counts as hot
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      over_ff <= 1'b0;
    end else begin
      over_ff <= (die_temp > threshold);
    end
  end

endmodule : bsio_heat_cmp

// ---- src/bsio_regs.sv ----
`timescale 1ns/1ps

// Summary of operation
// - Control bit 7 drives lamp, low lights
// - Control bit 5 reads over-temperature, read-only
// - Temperature compared with threshold every cycle
// - Reserved bits have no effect when written
// - Identity register answers at 1D1h
// - Identity bits 7:3 hold fixed product code
// - Identity bit 2 gives temperature grade
// - Identity bits 1:0 hold fixed revision
// - Jumper bit 6 mirrors video firmware jumper
// - Jumper bit 5 mirrors system firmware jumper
// - Transceiver bit 6 enables port4 485 transmitter
// - Transceiver bit 5 enables port4 receiver
// - Transceiver bit 4 enables port4 422 transmitter
// - Transceiver bit 2 enables port3 485 transmitter
// - Transceiver bit 1 enables port3 receiver
// - Transceiver bit 0 enables port3 422 transmitter
// - Disabled peripheral ranges are not claimed
module bsio_regs
  import bsio_pkg::*;
#(
  parameter int         TEMP_W       = 8,
  parameter logic [4:0] PRODUCT_CODE = 5'h15, // Arbitrary value
  parameter logic [1:0] REVISION     = 2'h2   // Arbitrary value
) (
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // Host I/O cycle
  input  wire logic [15:0]       IO_ADDR,
  input  wire logic              IO_RD,
  input  wire logic              IO_WR,
  input  wire logic [7:0]        IO_WDATA,
  output logic      [7:0]        IO_RDATA,
  output logic                   IO_CLAIM,
  // Thermometer and configuration
  input  wire logic [TEMP_W-1:0] DIE_TEMP,
  input  wire logic [TEMP_W-1:0] HEAT_THRESHOLD,
  input  wire logic              WIDE_TEMP_GRADE,
  input  wire logic              PORT3_ENABLED,
  input  wire logic              PORT4_ENABLED,
  // Jumpers
  input  wire logic              VIDEO_FW_JUMPER,
  input  wire logic              SYSTEM_FW_JUMPER,
  // Lamp and transceiver enables
  output logic                   INDICATOR_LAMP_N,
  output logic                   PORT4_TX485_EN,
  output logic                   PORT4_RX_DIFF_EN,
  output logic                   PORT4_TX422_EN,
  output logic                   PORT3_TX485_EN,
  output logic                   PORT3_RX_DIFF_EN,
  output logic                   PORT3_TX422_EN
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic own_reg(input logic [15:0] a);
    own_reg = (a == BSIO_ADDR_CTRL) || (a == BSIO_ADDR_IDENT) ||
              (a == BSIO_ADDR_JUMPER) || (a == BSIO_ADDR_XCVR);
  endfunction : own_reg

  logic             indicator_lamp_ctl_ff;
  logic [7:0]       xcvr_ff;
  logic             die_heat_flag;
  logic [7:0]       nxt_rdata;
  logic             nxt_claim;
  logic             wr_ctrl;
  logic             wr_xcvr;

  // ----------------------------------------------------------------
  // Temperature monitor
  // ----------------------------------------------------------------
  bsio_heat_cmp #(
    .TEMP_W    (TEMP_W)
  ) u_heat (
    .clk       (CLOCK),
    .rst       (RST),
    .die_temp  (DIE_TEMP),
    .threshold (HEAT_THRESHOLD),
    .over_ff   (die_heat_flag)
  );

  // Exact byte decode of the write strobes
  assign wr_ctrl = IO_WR && (IO_ADDR == BSIO_ADDR_CTRL);
  assign wr_xcvr = IO_WR && (IO_ADDR == BSIO_ADDR_XCVR);

  // ----------------------------------------------------------------
  // Writable state
  // ----------------------------------------------------------------
  // Only bit 7 of the control register is storage; the rest is dropped
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      indicator_lamp_ctl_ff <= BSIO_LAMP_RESET;
    end else if (wr_ctrl) begin
      indicator_lamp_ctl_ff <= IO_WDATA[BSIO_CTRL_LAMP_BIT];
    end
  end

  // Reserved transceiver bits are masked so they never store
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      xcvr_ff <= BSIO_XC_RESET;
    end else if (wr_xcvr) begin
      xcvr_ff <= IO_WDATA & BSIO_XC_WMASK;
    end
  end

  // Lamp pin is active low, so the stored bit drives it directly
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      INDICATOR_LAMP_N <= BSIO_LAMP_RESET;
    end else begin
      INDICATOR_LAMP_N <= indicator_lamp_ctl_ff;
    end
  end

  // Transceiver enables, one flop each so outputs are glitch free
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PORT4_TX485_EN   <= 1'b0;
      PORT4_RX_DIFF_EN <= 1'b0;
      PORT4_TX422_EN   <= 1'b0;
      PORT3_TX485_EN   <= 1'b0;
      PORT3_RX_DIFF_EN <= 1'b0;
      PORT3_TX422_EN   <= 1'b0;
    end else begin
      PORT4_TX485_EN   <= xcvr_ff[BSIO_XC_P4_TX485_BIT];
      PORT4_RX_DIFF_EN <= xcvr_ff[BSIO_XC_P4_RX_BIT];
      PORT4_TX422_EN   <= xcvr_ff[BSIO_XC_P4_TX422_BIT];
      PORT3_TX485_EN   <= xcvr_ff[BSIO_XC_P3_TX485_BIT];
      PORT3_RX_DIFF_EN <= xcvr_ff[BSIO_XC_P3_RX_BIT];
      PORT3_TX422_EN   <= xcvr_ff[BSIO_XC_P3_TX422_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read mux and address claim
  // ----------------------------------------------------------------
  // Unmapped reads return the reserved constant
  always_comb begin
    nxt_rdata = BSIO_RSVD_VALUE;
    case (IO_ADDR)
      BSIO_ADDR_CTRL: begin
        nxt_rdata[BSIO_CTRL_LAMP_BIT] = indicator_lamp_ctl_ff;
        nxt_rdata[BSIO_CTRL_HEAT_BIT] = die_heat_flag;
      end
      BSIO_ADDR_IDENT: begin
        nxt_rdata = {PRODUCT_CODE, WIDE_TEMP_GRADE, REVISION};
      end
      BSIO_ADDR_JUMPER: begin
        nxt_rdata[BSIO_JMP_VIDEO_BIT]  = VIDEO_FW_JUMPER;
        nxt_rdata[BSIO_JMP_SYSTEM_BIT] = SYSTEM_FW_JUMPER;
      end
      BSIO_ADDR_XCVR: begin
        nxt_rdata = xcvr_ff;
      end
      default: begin
        nxt_rdata = BSIO_RSVD_VALUE;
      end
    endcase
  end

  // Serial ranges are released when their port is configured off
  always_comb begin
    nxt_claim = own_reg(IO_ADDR) ||
                (PORT3_ENABLED && in_range(IO_ADDR, BSIO_ADDR_PORT3_LO,
                                           BSIO_ADDR_PORT3_HI)) ||
                (PORT4_ENABLED && in_range(IO_ADDR, BSIO_ADDR_PORT4_LO,
                                           BSIO_ADDR_PORT4_HI));
  end

  // Read data is registered; it appears one cycle after the read strobe
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      IO_RDATA <= BSIO_RSVD_VALUE;
    end else if (IO_RD) begin
      IO_RDATA <= nxt_rdata;
    end
  end

  // Claim is a registered response to any strobed cycle at an own register or an enabled serial range
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      IO_CLAIM <= 1'b0;
    end else begin
      IO_CLAIM <= (IO_RD || IO_WR) && nxt_claim;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_lamp;
    @(posedge CLOCK) disable iff (RST)
      wr_ctrl |-> ##2 (INDICATOR_LAMP_N == $past(IO_WDATA[BSIO_CTRL_LAMP_BIT], 2));
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp not following write");

  property p_heat_rd;
    @(posedge CLOCK) disable iff (RST)
      (IO_RD && IO_ADDR == BSIO_ADDR_CTRL) |=> (IO_RDATA[5] == $past(die_heat_flag));
  endproperty
  a_heat_rd: assert property (p_heat_rd) else $error("heat flag read wrong");

  property p_heat_cmp;
    @(posedge CLOCK) disable iff (RST)
      1'b1 |=> (die_heat_flag == ($past(DIE_TEMP) > $past(HEAT_THRESHOLD)));
  endproperty
  a_heat_cmp: assert property (p_heat_cmp) else $error("heat compare wrong");

  property p_rsvd;
    @(posedge CLOCK) disable iff (RST)
      wr_xcvr |=> (xcvr_ff[7] == 1'b0) && (xcvr_ff[3] == 1'b0);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit stored");

  property p_ident;
    @(posedge CLOCK) disable iff (RST)
      (IO_RD && IO_ADDR == BSIO_ADDR_IDENT) |=>
        (IO_RDATA[7:3] == PRODUCT_CODE) && (IO_RDATA[1:0] == REVISION) &&
        (IO_RDATA[2] == $past(WIDE_TEMP_GRADE));
  endproperty
  a_ident: assert property (p_ident) else $error("identity read wrong");

  property p_jumper;
    @(posedge CLOCK) disable iff (RST)
      (IO_RD && IO_ADDR == BSIO_ADDR_JUMPER) |=>
        (IO_RDATA == {1'b0, $past(VIDEO_FW_JUMPER), $past(SYSTEM_FW_JUMPER), 5'h00});
  endproperty
  a_jumper: assert property (p_jumper) else $error("jumper read wrong");

  property p_p4tx;
    @(posedge CLOCK) disable iff (RST)
      wr_xcvr |-> ##2 (PORT4_TX485_EN == $past(IO_WDATA[6], 2)) &&
                      (PORT3_TX422_EN == $past(IO_WDATA[0], 2));
  endproperty
  a_p4tx: assert property (p_p4tx) else $error("transceiver enable wrong");

  property p_release;
    @(posedge CLOCK) disable iff (RST)
      (IO_RD && !PORT3_ENABLED && IO_ADDR == BSIO_ADDR_PORT3_LO) |=> !IO_CLAIM;
  endproperty
  a_release: assert property (p_release) else $error("disabled range claimed");

  property p_unmapped;
    @(posedge CLOCK) disable iff (RST)
      (IO_RD && IO_ADDR == 16'h01d3) |=> (IO_RDATA == BSIO_RSVD_VALUE) && !IO_CLAIM;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("neighbour byte decoded");

  property p_lamp_rd;
    @(posedge CLOCK) disable iff (RST)
      (IO_RD && IO_ADDR == BSIO_ADDR_CTRL) |=>
        (IO_RDATA[BSIO_CTRL_LAMP_BIT] == INDICATOR_LAMP_N);
  endproperty
  a_lamp_rd: assert property (p_lamp_rd) else $error("lamp readback wrong");

  property p_ctrl_rsvd;
    @(posedge CLOCK) disable iff (RST)
      (IO_RD && IO_ADDR == BSIO_ADDR_CTRL) |=>
        (IO_RDATA[6] == 1'b0) && (IO_RDATA[4:0] == 5'h00);
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved bit set");

  property p_heat_ro;
    @(posedge CLOCK) disable iff (RST)
      (wr_ctrl && IO_WDATA[BSIO_CTRL_HEAT_BIT] && !(DIE_TEMP > HEAT_THRESHOLD)) |=>
        !die_heat_flag;
  endproperty
  a_heat_ro: assert property (p_heat_ro) else $error("heat flag taken from write");

  property p_ident_claim;
    @(posedge CLOCK) disable iff (RST)
      (IO_RD && IO_ADDR == BSIO_ADDR_IDENT) |=> IO_CLAIM;
  endproperty
  a_ident_claim: assert property (p_ident_claim) else $error("identity not claimed");

  property p_grade;
    @(posedge CLOCK) disable iff (RST)
      (IO_RD && IO_ADDR == BSIO_ADDR_IDENT) |=>
        (IO_RDATA[BSIO_ID_GRADE_BIT] == $past(WIDE_TEMP_GRADE));
  endproperty
  a_grade: assert property (p_grade) else $error("grade bit wrong");

  property p_rev;
    @(posedge CLOCK) disable iff (RST)
      (IO_RD && IO_ADDR == BSIO_ADDR_IDENT) |=> (IO_RDATA[1:0] == REVISION);
  endproperty
  a_rev: assert property (p_rev) else $error("revision field wrong");

  property p_sysjmp;
    @(posedge CLOCK) disable iff (RST)
      (IO_RD && IO_ADDR == BSIO_ADDR_JUMPER) |=>
        (IO_RDATA[BSIO_JMP_SYSTEM_BIT] == $past(SYSTEM_FW_JUMPER));
  endproperty
  a_sysjmp: assert property (p_sysjmp) else $error("system jumper bit wrong");

  property p_p4rx;
    @(posedge CLOCK) disable iff (RST)
      wr_xcvr |-> ##2 (PORT4_RX_DIFF_EN == $past(IO_WDATA[BSIO_XC_P4_RX_BIT], 2));
  endproperty
  a_p4rx: assert property (p_p4rx) else $error("port4 receiver enable wrong");

  property p_p4tx422;
    @(posedge CLOCK) disable iff (RST)
      wr_xcvr |-> ##2 (PORT4_TX422_EN == $past(IO_WDATA[BSIO_XC_P4_TX422_BIT], 2));
  endproperty
  a_p4tx422: assert property (p_p4tx422) else $error("port4 422 enable wrong");

  property p_p3tx485;
    @(posedge CLOCK) disable iff (RST)
      wr_xcvr |-> ##2 (PORT3_TX485_EN == $past(IO_WDATA[BSIO_XC_P3_TX485_BIT], 2));
  endproperty
  a_p3tx485: assert property (p_p3tx485) else $error("port3 485 enable wrong");

  property p_p3rx;
    @(posedge CLOCK) disable iff (RST)
      wr_xcvr |-> ##2 (PORT3_RX_DIFF_EN == $past(IO_WDATA[BSIO_XC_P3_RX_BIT], 2));
  endproperty
  a_p3rx: assert property (p_p3rx) else $error("port3 receiver enable wrong");

  property p_p3tx422;
    @(posedge CLOCK) disable iff (RST)
      wr_xcvr |-> ##2 (PORT3_TX422_EN == $past(IO_WDATA[BSIO_XC_P3_TX422_BIT], 2));
  endproperty
  a_p3tx422: assert property (p_p3tx422) else $error("port3 422 enable wrong");

  property p_p4_release;
    @(posedge CLOCK) disable iff (RST)
      (IO_RD && !PORT4_ENABLED && IO_ADDR == BSIO_ADDR_PORT4_LO) |=> !IO_CLAIM;
  endproperty
  a_p4_release: assert property (p_p4_release) else $error("port4 range claimed");

  property p_claim_reg;
    @(posedge CLOCK) disable iff (RST)
      ((IO_RD || IO_WR) && IO_ADDR == BSIO_ADDR_XCVR) |=> IO_CLAIM;
  endproperty
  a_claim_reg: assert property (p_claim_reg) else $error("register not claimed");

  property p_rdata_hold;
    @(posedge CLOCK) disable iff (RST)
      !IO_RD |=> $stable(IO_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_lamp_hold;
    @(posedge CLOCK) disable iff (RST)
      !wr_ctrl |=> $stable(indicator_lamp_ctl_ff);
  endproperty
  a_lamp_hold: assert property (p_lamp_hold) else $error("lamp bit moved");

endmodule : bsio_regs

// ---- bench/bsio_board_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Board side: thermometer, jumpers and indicator lamp
// ----------------------------------------------------------------
module bsio_board_model (
  // Settings from the bench
  input  wire logic [7:0] set_temp,
  input  wire logic [7:0] set_thr,
  input  wire logic [1:0] set_jmp,
  // Pins toward the block
  output logic      [7:0] die_temp,
  output logic      [7:0] threshold,
  output logic            video_jmp,
  output logic            system_jmp,
  input  wire logic       lamp_n,
  output logic            lamp_lit
);
  // Sensor and jumpers are static levels; no settling time modelled
  assign die_temp   = set_temp;
  assign threshold  = set_thr;
  assign video_jmp  = set_jmp[1];
  assign system_jmp = set_jmp[0];
  // Lamp lights while its drive line is low
  assign lamp_lit   = ~lamp_n;
endmodule : bsio_board_model

// ---- bench/bsio_regs_tb_top.sv ----
`timescale 1ns/1ps
`define BSIO_CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); end end

module bsio_regs_tb_top;
  import bsio_pkg::*;
  localparam logic [4:0] PCODE = 5'h0b; // Arbitrary value
  localparam logic [1:0] REV   = 2'h1;  // Arbitrary value
  logic       clock, rst, io_rd, io_wr, wide, p3en, p4en, vj, sj, lamp_n, lit;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, temp, thr, dt, th;
  logic [1:0] jmp;
  logic       claim;
  wire  [5:0] en;
  int         fails, checks_done;

  bsio_board_model board (.set_temp(temp), .set_thr(thr), .set_jmp(jmp), .die_temp(dt),
    .threshold(th), .video_jmp(vj), .system_jmp(sj), .lamp_n(lamp_n), .lamp_lit(lit));

  bsio_regs #(.TEMP_W(8), .PRODUCT_CODE(PCODE), .REVISION(REV)) dut (
    .CLOCK(clock), .RST(rst), .IO_ADDR(io_addr), .IO_RD(io_rd), .IO_WR(io_wr),
    .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_CLAIM(claim), .DIE_TEMP(dt),
    .HEAT_THRESHOLD(th), .WIDE_TEMP_GRADE(wide), .PORT3_ENABLED(p3en),
    .PORT4_ENABLED(p4en), .VIDEO_FW_JUMPER(vj), .SYSTEM_FW_JUMPER(sj),
    .INDICATOR_LAMP_N(lamp_n), .PORT4_TX485_EN(en[5]), .PORT4_RX_DIFF_EN(en[4]),
    .PORT4_TX422_EN(en[3]), .PORT3_TX485_EN(en[2]), .PORT3_RX_DIFF_EN(en[1]),
    .PORT3_TX422_EN(en[0]));

  // ----------------------------------------------------------------
  // Bus cycle: strobe for one edge; answer is settled on return
  // ----------------------------------------------------------------
  // Waits an edge first so a strobe is never lowered and raised at once
  task automatic cyc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock); #1;
    io_addr = a; io_wdata = d; io_wr = wr; io_rd = !wr;
    @(posedge clock); #1;
    io_rd = 1'b0; io_wr = 1'b0;
  endtask : cyc

  task automatic t_reset;
    `BSIO_CHK({lamp_n, en, claim, io_rdata}, 16'h8000)
    $display("test reset done");
  endtask : t_reset

  // Lamp drive, heat flag and reserved control bits
  task automatic t_ctrl;
    temp = 8'h41; thr = 8'h40;
    cyc(1'b1, BSIO_ADDR_CTRL, 8'h7f);
    @(posedge clock); #1;
    `BSIO_CHK(lit, 1'b1)
    cyc(1'b0, BSIO_ADDR_CTRL, 8'h00);
    `BSIO_CHK(io_rdata, 8'h20)
    temp = 8'h40;
    cyc(1'b0, BSIO_ADDR_CTRL, 8'h00);
    `BSIO_CHK(io_rdata, 8'h00)
    cyc(1'b1, BSIO_ADDR_CTRL, 8'hff);
    @(posedge clock); #1;
    `BSIO_CHK(lamp_n, 1'b1)
    cyc(1'b0, BSIO_ADDR_CTRL, 8'h00);
    `BSIO_CHK(io_rdata, 8'h80)
    thr = 8'h3f;
    cyc(1'b0, BSIO_ADDR_CTRL, 8'h00);
    `BSIO_CHK(io_rdata, 8'ha0)
    $display("test control done");
  endtask : t_ctrl

  // Identity fields for both grades; writes must not alter them
  task automatic t_ident;
    for (int g = 0; g < 2; g++) begin
      wide = g[0];
      cyc(1'b1, BSIO_ADDR_IDENT, 8'hff);
      cyc(1'b0, BSIO_ADDR_IDENT, 8'h00);
      `BSIO_CHK(io_rdata, {PCODE, g[0], REV})
      `BSIO_CHK(claim, 1'b1)
    end
    $display("test identity done");
  endtask : t_ident

  // Every jumper combination, with a write of ones in between
  task automatic t_jumper;
    for (int j = 0; j < 4; j++) begin
      jmp = j[1:0];
      cyc(1'b1, BSIO_ADDR_JUMPER, 8'hff);
      cyc(1'b0, BSIO_ADDR_JUMPER, 8'h00);
      `BSIO_CHK(io_rdata, {1'b0, j[1:0], 5'h00})
    end
    $display("test jumper done");
  endtask : t_jumper

  // Walking one over all eight bits, reserved ones included
  task automatic t_xcvr;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 8'h01 << i;
      cyc(1'b1, BSIO_ADDR_XCVR, v);
      @(posedge clock); #1;
      `BSIO_CHK(en, {v[6:4], v[2:0]})
      cyc(1'b0, BSIO_ADDR_XCVR, 8'h00);
      `BSIO_CHK(io_rdata, v & 8'h77)
    end
    $display("test transceiver done");
  endtask : t_xcvr

  // Claims at range edges, with the serial ports on and off
  task automatic t_decode;
    logic [15:0] a [8] = '{16'h01d3, 16'h01cf, 16'h03e8, 16'h03ef, 16'h03e8,
                           16'h02ef, 16'h02f0, 16'h02e8};
    logic [7:0] cfg = 8'b0010_1101;
    logic [7:0] exp = 8'b0010_1100;
    for (int k = 0; k < 8; k++) begin
      p3en = cfg[k]; p4en = cfg[k];
      cyc(1'b0, a[k], 8'h00);
      `BSIO_CHK(claim, exp[k])
      if (k < 2) `BSIO_CHK(io_rdata, 8'h00)
    end
    $display("test decode done");
  endtask : t_decode

  // Reset in mid-run must bring lamp and drivers back to idle
  task automatic t_midrst;
    cyc(1'b1, BSIO_ADDR_XCVR, 8'h77);
    cyc(1'b1, BSIO_ADDR_CTRL, 8'h00);
    @(posedge clock); #1;
    `BSIO_CHK({lamp_n, en}, 7'h3f)
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    `BSIO_CHK({lamp_n, en, claim}, 8'h80)
    cyc(1'b0, BSIO_ADDR_XCVR, 8'h00);
    `BSIO_CHK(io_rdata, BSIO_XC_RESET)
    $display("test mid-run reset done");
  endtask : t_midrst

  task automatic end_of_test;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Clock at 200 MHz
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Main sequence after a 12-cycle reset
  initial begin
    {rst, io_rd, io_wr, wide, p3en, p4en} = 6'b100000;
    io_addr = 16'h0000; io_wdata = 8'h00; temp = 8'h00; thr = 8'h00; jmp = 2'b00;
    fails = 0; checks_done = 0;
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    t_reset();
    t_ctrl();
    t_ident();
    t_jumper();
    t_xcvr();
    t_decode();
    t_midrst();
    end_of_test();
  end

  // Watchdog: the whole run needs about 115 cycles
  initial begin
    #20000;
    fails++;
    end_of_test();
  end
endmodule : bsio_regs_tb_top
